// *** hw/rf_converter_control.sv ***
// R/F converter control: AHB-Lite registers, counters and oscillation control.
// Summary of operation
// - Channel select bit picks channel; reset 0.
// - Triggers reach selected channel only; settings are shared by both.
// - Conversion starts only while enable bit set.
// - Trigger writes ignored while converter disabled.
// - Trigger bits: B=D2, A=D1, ref=D0.
// - Write 1 starts, write 0 stops oscillation.
// - Trigger bit reads back running status.
// - Sensor B blocked in AC-res, DC-cap modes.
// - 24-bit measurement counter, low/high halves.
// - 24-bit time base counter, low/high halves.
// - Mask D4 enables time base overflow.
// - Mask D3 enables measurement overflow.
// - Mask D2 enables sensor B completion.
// - Mask D1, D0 enable sensor A, reference.
// - Measurement overflow ends reference, sets flag.
// - Time base reaching zero ends sensor run.
// - Time base overflow aborts reference, flags error.
// - Writing 1 clears a flag; 0 ignored.
//
// Implementation choice: the AHB-Lite slave port.
`default_nettype none
module rf_converter_control
  import rf_conv_pkg::*;
#(
  parameter int CNT_W = 24
) (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Oscillator clocks per channel and the time base count clock.
  input  wire logic [1:0]  rfIn,
  input  wire logic        tcClk,
  // Oscillator control per channel and shared settings.
  output logic [TRG_W-1:0] oscRunCh0,
  output logic [TRG_W-1:0] oscRunCh1,
  output logic [1:0]       oscillationMode,
  output logic             eventMode,
  output logic             irq
);
  localparam int HI_W = CNT_W - LO_W;
  localparam logic [CNT_W-1:0] CNT_MAX = '1;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  // Bus slave state.
  bus_state_e  busSt_r, busSt_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic        write_r, write_nxt;
  logic        hready_r, hready_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  // Core state.
  logic [15:0]       ctl_r, ctl_nxt;
  logic [TRG_W-1:0]  trig_r, trig_nxt;
  logic [CNT_W-1:0]  mc_r, mc_nxt;
  logic [CNT_W-1:0]  tc_r, tc_nxt;
  logic [FLG_W-1:0]  msk_r, msk_nxt;
  logic [FLG_W-1:0]  flg_r, flg_nxt;
  logic [TRG_W-1:0]  run0_r, run0_nxt, run1_r, run1_nxt;
  logic              irq_r, irq_nxt;
  // Synchronisers and edge detectors.
  logic [1:0] rfSync1_r, rfSync2_r;
  logic       oscPrev_r, tcSync1_r, tcSync2_r, tcPrev_r;
  logic       oscSel, oscEdge, tick, wrStb, sensorRun, cont;
  logic       mcOv, tcOv, tcZero;
  logic [FLG_W-1:0] setFlg, clrFlg;

  // Pins from other domains pass two flops before any logic reads them.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rfSync1_r <= 2'h0;
      rfSync2_r <= 2'h0;
      oscPrev_r <= 1'b0;
      tcSync1_r <= 1'b0;
      tcSync2_r <= 1'b0;
      tcPrev_r  <= 1'b0;
    end else begin
      rfSync1_r <= rfIn;
      rfSync2_r <= rfSync1_r;
      oscPrev_r <= oscSel;
      tcSync1_r <= tcClk;
      tcSync2_r <= tcSync1_r;
      tcPrev_r  <= tcSync2_r;
    end
  end

  // Only the selected channel's oscillator feeds the counter.
  assign oscSel  = ctl_r[CTL_CHANNEL_SELECT] ? rfSync2_r[1] : rfSync2_r[0];
  assign oscEdge = oscSel & ~oscPrev_r;
  assign tick    = tcSync2_r & ~tcPrev_r;
  assign wrStb   = (busSt_r == BUS_WAIT) & write_r;

  // One wait state per transfer lets reads see the previous write.
  always_comb begin
    busSt_nxt  = busSt_r;
    addr_nxt   = addr_r;
    write_nxt  = write_r;
    hready_nxt = 1'b1;
    rdata_nxt  = rdata_r;
    case (busSt_r)
      BUS_IDLE: begin
        if (hsel && hready && htrans == HTRANS_NONSEQ) begin
          busSt_nxt  = BUS_WAIT;
          addr_nxt   = haddr;
          write_nxt  = hwrite;
          hready_nxt = 1'b0;
        end
      end
      BUS_WAIT: begin
        busSt_nxt = BUS_IDLE;
        rdata_nxt = 32'h0000_0000;
        if (addr_r == regAddr(IDX_CTL)) begin
          rdata_nxt[15:0] = ctl_r;
        end else if (addr_r == regAddr(IDX_TRG)) begin
          rdata_nxt[TRG_W-1:0] = trig_r;
        end else if (addr_r == regAddr(IDX_MCL)) begin
          rdata_nxt[LO_W-1:0] = mc_r[LO_W-1:0];
        end else if (addr_r == regAddr(IDX_MCH)) begin
          rdata_nxt[HI_W-1:0] = mc_r[CNT_W-1:LO_W];
        end else if (addr_r == regAddr(IDX_TCL)) begin
          rdata_nxt[LO_W-1:0] = tc_r[LO_W-1:0];
        end else if (addr_r == regAddr(IDX_TCH)) begin
          rdata_nxt[HI_W-1:0] = tc_r[CNT_W-1:LO_W];
        end else if (addr_r == regAddr(IDX_IMSK)) begin
          rdata_nxt[FLG_W-1:0] = msk_r;
        end else if (addr_r == regAddr(IDX_IFLG)) begin
          rdata_nxt[FLG_W-1:0] = flg_r;
        end
      end
      default: busSt_nxt = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      busSt_r  <= BUS_IDLE;
      addr_r   <= 32'h0000_0000;
      write_r  <= 1'b0;
      hready_r <= 1'b1;
      rdata_r  <= 32'h0000_0000;
    end else begin
      busSt_r  <= busSt_nxt;
      addr_r   <= addr_nxt;
      write_r  <= write_nxt;
      hready_r <= hready_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // Stop conditions; continuous mode disables all of them.
  assign cont      = ctl_r[CTL_CONT];
  assign sensorRun = trig_r[TRG_SNA] | trig_r[TRG_SNB];
  assign mcOv      = (|trig_r) & oscEdge & (mc_r == CNT_MAX);
  assign tcOv      = trig_r[TRG_REF] & tick & (tc_r == CNT_MAX);
  assign tcZero    = sensorRun & tick & (tc_r == CNT_ONE);

  // Counters, triggers, flags and the interrupt request.
  always_comb begin
    ctl_nxt  = ctl_r;
    trig_nxt = trig_r;
    mc_nxt   = mc_r;
    tc_nxt   = tc_r;
    msk_nxt  = msk_r;
    setFlg   = '0;
    clrFlg   = '0;
    // The reference run counts time base up; sensor runs count it down.
    if (|trig_r && oscEdge) begin
      mc_nxt = mc_r + CNT_ONE;
    end
    if (trig_r[TRG_REF] && tick) begin
      tc_nxt = tc_r + CNT_ONE;
    end else if (sensorRun && tick && tc_r != '0) begin
      tc_nxt = tc_r - CNT_ONE;
    end
    if (!cont) begin
      if (trig_r[TRG_REF] && mcOv) begin
        setFlg[TRG_REF] = 1'b1;
        trig_nxt        = '0;
      end else if (tcOv) begin
        setFlg[FLG_TCOV] = 1'b1;
        trig_nxt         = '0;
      end
      if (tcZero) begin
        setFlg[TRG_W-1:0] = trig_r & ~TRG_W'(1);
        trig_nxt          = '0;
      end else if (sensorRun && mcOv) begin
        setFlg[FLG_MCOV] = 1'b1;
        trig_nxt         = '0;
      end
    end
    // Software writes take effect at the end of the wait state.
    if (wrStb) begin
      if (addr_r == regAddr(IDX_CTL)) begin
        ctl_nxt = hwdata[15:0] & CTL_MASK;
      end else if (addr_r == regAddr(IDX_TRG)) begin
        if (ctl_r[CTL_EN]) begin
          trig_nxt = hwdata[TRG_W-1:0];
          if (!trig_r[TRG_SNB] &&
              (ctl_r[CTL_MODE+:2] == MODE_AC_RES ||
               ctl_r[CTL_MODE+:2] == MODE_DC_CAP)) begin
            trig_nxt[TRG_SNB] = 1'b0;
          end
        end
      end else if (addr_r == regAddr(IDX_MCL)) begin
        mc_nxt[LO_W-1:0] = hwdata[LO_W-1:0];
      end else if (addr_r == regAddr(IDX_MCH)) begin
        mc_nxt[CNT_W-1:LO_W] = hwdata[HI_W-1:0];
      end else if (addr_r == regAddr(IDX_TCL)) begin
        tc_nxt[LO_W-1:0] = hwdata[LO_W-1:0];
      end else if (addr_r == regAddr(IDX_TCH)) begin
        tc_nxt[CNT_W-1:LO_W] = hwdata[HI_W-1:0];
      end else if (addr_r == regAddr(IDX_IMSK)) begin
        msk_nxt = hwdata[FLG_W-1:0];
      end else if (addr_r == regAddr(IDX_IFLG)) begin
        clrFlg = hwdata[FLG_W-1:0];
      end
    end
    // A new event in the clearing cycle is kept: set wins.
    flg_nxt  = (flg_r & ~clrFlg) | setFlg;
    irq_nxt  = |(flg_nxt & msk_nxt);
    run0_nxt = ctl_nxt[CTL_CHANNEL_SELECT] ? '0 : trig_nxt;
    run1_nxt = ctl_nxt[CTL_CHANNEL_SELECT] ? trig_nxt : '0;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_r  <= RST_WORD;
      trig_r <= '0;
      mc_r   <= '0;
      tc_r   <= '0;
      msk_r  <= '0;
      flg_r  <= '0;
      run0_r <= '0;
      run1_r <= '0;
      irq_r  <= 1'b0;
    end else begin
      ctl_r  <= ctl_nxt;
      trig_r <= trig_nxt;
      mc_r   <= mc_nxt;
      tc_r   <= tc_nxt;
      msk_r  <= msk_nxt;
      flg_r  <= flg_nxt;
      run0_r <= run0_nxt;
      run1_r <= run1_nxt;
      irq_r  <= irq_nxt;
    end
  end

  // All outputs but the tied-off hresp come straight from flops.
  assign hreadyout       = hready_r;
  assign hrdata          = rdata_r;
  assign hresp           = HRESP_OKAY;
  assign oscRunCh0       = run0_r;
  assign oscRunCh1       = run1_r;
  assign oscillationMode = ctl_r[CTL_MODE+:2];
  assign eventMode       = ctl_r[CTL_EVT];
  assign irq             = irq_r;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_irq_mask_gate: assert property (
    irq == |(flg_r & msk_r))
    else $error("irq does not match flags and mask");
  a_trig_write_off: assert property (
    wrStb && addr_r == regAddr(IDX_TRG) && !ctl_r[CTL_EN]
    |=> (trig_r & ~$past(trig_r)) == '0)
    else $error("trigger started while converter disabled");
  a_trig_start_ref: assert property (
    wrStb && addr_r == regAddr(IDX_TRG) && ctl_r[CTL_EN] &&
    hwdata[TRG_REF] |=> trig_r[TRG_REF])
    else $error("reference did not start on write");
  a_snb_mode_block: assert property (
    wrStb && addr_r == regAddr(IDX_TRG) && !trig_r[TRG_SNB] &&
    (ctl_r[CTL_MODE+:2] == MODE_AC_RES ||
     ctl_r[CTL_MODE+:2] == MODE_DC_CAP) |=> !trig_r[TRG_SNB])
    else $error("sensor B started in forbidden mode");
  a_ref_done_stop: assert property (
    trig_r[TRG_REF] && mcOv && !cont && !wrStb
    |=> flg_r[TRG_REF] && !trig_r[TRG_REF])
    else $error("reference completion not flagged");
  a_sensor_done: assert property (
    tcZero && !cont && !wrStb
    |=> (flg_r[TRG_W-1:0] & $past(trig_r)) == $past(trig_r) &&
        trig_r == '0)
    else $error("sensor completion not flagged");
  a_tc_overflow: assert property (
    tcOv && !mcOv && !cont && !wrStb |=> flg_r[FLG_TCOV])
    else $error("time base overflow not flagged");
  a_set_wins_clr: assert property (
    setFlg[TRG_REF] && clrFlg[TRG_REF] |=> flg_r[TRG_REF])
    else $error("flag event lost on clear");
  a_chan_route: assert property (
    oscRunCh1 == (ctl_r[CTL_CHANNEL_SELECT] ? trig_r : '0) &&
    oscRunCh0 == (ctl_r[CTL_CHANNEL_SELECT] ? '0 : trig_r))
    else $error("oscillation routed to wrong channel");
  a_bus_one_wait: assert property (
    busSt_r == BUS_IDLE && hsel && hready && htrans == HTRANS_NONSEQ
    |=> !hreadyout ##1 hreadyout)
    else $error("bus wait state not one cycle");
  a_cont_keeps_run: assert property (
    cont && |trig_r && !wrStb |=> trig_r == $past(trig_r))
    else $error("continuous oscillation stopped by hardware");
endmodule
`default_nettype wire

// *** common/rf_conv_pkg.sv ***
// Package of register map, field layout and types for the R/F converter.
`default_nettype none
package rf_conv_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_CTL  = 16'h53a0;
  localparam logic [15:0] IDX_TRG  = 16'h53a2;
  localparam logic [15:0] IDX_MCL  = 16'h53a4;
  localparam logic [15:0] IDX_MCH  = 16'h53a6;
  localparam logic [15:0] IDX_TCL  = 16'h53a8;
  localparam logic [15:0] IDX_TCH  = 16'h53aa;
  localparam logic [15:0] IDX_IMSK = 16'h53ac;
  localparam logic [15:0] IDX_IFLG = 16'h53ae;
  // Control register fields and writable mask.
  localparam int          CTL_EN    = 0;
  localparam int          CTL_CHANNEL_SELECT = 1;
  localparam int          CTL_MODE  = 4;
  localparam int          CTL_EVT   = 6;
  localparam int          CTL_CONT  = 7;
  localparam logic [15:0] CTL_MASK  = 16'h00f3;
  // Trigger bits and flag/mask bits.
  localparam int          TRG_REF  = 0;
  localparam int          TRG_SNA  = 1;
  localparam int          TRG_SNB  = 2;
  localparam int          FLG_MCOV = 3;
  localparam int          FLG_TCOV = 4;
  localparam int          TRG_W    = 3;
  localparam int          FLG_W    = 5;
  localparam int          LO_W     = 16;
  // Oscillation modes.
  localparam logic [1:0]  MODE_AC_RES = 2'h1;
  localparam logic [1:0]  MODE_DC_CAP = 2'h2;
  // Reset values.
  localparam logic [15:0] RST_WORD = 16'h0000;
  // AHB-Lite encodings.
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'b0;
  // Bus slave states.
  typedef enum logic {BUS_IDLE = 1'b0, BUS_WAIT = 1'b1} bus_state_e;
  // Byte address of a register index.
  function automatic logic [31:0] regAddr(input logic [15:0] idx);
    return {14'h0000, idx, 2'b00};
  endfunction
endpackage
`default_nettype wire

// *** verif/rf_sensor_model.sv ***
// Behavioural model of the sensor CR oscillators on both channels.
`default_nettype none
module rf_sensor_model
  import rf_conv_pkg::*;
#(
  parameter int HALF_NS = 24
) (
  // Run requests per channel from the converter.
  input  wire logic [TRG_W-1:0] runCh0,
  input  wire logic [TRG_W-1:0] runCh1,
  // Oscillator output per channel.
  output logic      [1:0]       rfOut
);
  timeunit 1ns;
  timeprecision 1ps;

  // A stopped oscillator falls to the pin's pull-down level, so a stale
  // high level can never pass for a live clock.
  initial begin
    rfOut = 2'b00;
    forever begin
      #HALF_NS;
      rfOut[0] = (|runCh0) ? ~rfOut[0] : 1'b0;
      rfOut[1] = (|runCh1) ? ~rfOut[1] : 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** verif/rf_converter_control_tb_top.sv ***
// Testbench top: register bus, oscillation control, counters and flags.
`default_nettype none
module rf_converter_control_tb_top;
  import rf_conv_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // Bus, clocks and design outputs.
  logic             clock = 1'b0;
  logic             sys_rst = 1'b1;
  logic             tcClk = 1'b0;
  logic             hwrite = 1'b0;
  logic [1:0]       htrans = 2'h0;
  logic [31:0]      haddr = 32'h0000_0000;
  logic [31:0]      hwdata = 32'h0000_0000;
  logic             hreadyout, hresp, eventMode, irq;
  logic [31:0]      hrdata;
  logic [1:0]       rfIn, oscillationMode;
  logic [TRG_W-1:0] oscRunCh0, oscRunCh1;
  int               failCount = 0;
  int               checkCount = 0;

  rf_converter_control DUT (.clock(clock), .sys_rst(sys_rst), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .rfIn(rfIn), .tcClk(tcClk),
    .oscRunCh0(oscRunCh0), .oscRunCh1(oscRunCh1),
    .oscillationMode(oscillationMode), .eventMode(eventMode), .irq(irq));

  rf_sensor_model PARTNER (.runCh0(oscRunCh0), .runCh1(oscRunCh1),
    .rfOut(rfIn));

  // System clock and a slower, unrelated time base count clock.
  initial begin
    forever #4 clock = ~clock;
  end
  initial begin
    forever #100 tcClk = ~tcClk;
  end

  task automatic endOfTest();
    if (failCount == 0 && checkCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] e, g);
    checkCount++;
    if (g !== e) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // One single word transfer; each phase waits for hready at an edge.
  task automatic bus(input logic wr, input logic [15:0] idx,
                     input logic [15:0] wd, output logic [31:0] rd);
    htrans <= HTRANS_NONSEQ;
    haddr  <= regAddr(idx);
    hwrite <= wr;
    @(posedge clock iff hreadyout === 1'b1);
    htrans <= 2'h0;
    hwdata <= {16'h0000, wd};
    @(posedge clock iff hreadyout === 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask

  task automatic rdChk(input string n, input logic [15:0] idx,
                       input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, idx, 16'h0000, x);
    check(n, e, x);
  endtask

  // Reset values, reserved bits and triggers while disabled.
  task automatic regsAfterReset();
    logic [15:0] ri [6];
    logic [31:0] rm [6];
    ri = '{IDX_TRG, IDX_MCL, IDX_MCH, IDX_TCL, IDX_TCH, IDX_IMSK};
    rm = '{32'h0, 32'hffff, 32'hff, 32'hffff, 32'hff, 32'h1f};
    rdChk("ctl", IDX_CTL, 32'h0);
    check("hresp", 32'h0, {31'h0, hresp});
    // Reserved control bits read back 0 and bit 6 reaches its pin.
    wr(IDX_CTL, 16'hffff);
    rdChk("ctlMask", IDX_CTL, 32'hf3);
    check("evtOn", 32'h1, {31'h0, eventMode});
    wr(IDX_CTL, 16'h0000);
    check("evtOff", 32'h0, {31'h0, eventMode});
    for (int i = 0; i < 6; i++) begin
      rdChk("rst", ri[i], 32'h0);
      wr(ri[i], 16'hffff);
      rdChk("rw", ri[i], rm[i]);
      wr(ri[i], 16'h0000);
    end
    check("run0", 32'h0, {29'h0, oscRunCh0});
  endtask

  // Triggers land on the selected channel only.
  task automatic channelSteer();
    wr(IDX_CTL, 16'h0003);
    wr(IDX_TRG, 16'h0002);
    rdChk("trg", IDX_TRG, 32'h2);
    check("ch1", 32'h2, {29'h0, oscRunCh1});
    check("ch0", 32'h0, {29'h0, oscRunCh0});
    wr(IDX_TRG, 16'h0000);
    rdChk("stop", IDX_TRG, 32'h0);
    wr(IDX_CTL, 16'h0001);
    wr(IDX_TRG, 16'h0001);
    check("ch0", 32'h1, {29'h0, oscRunCh0});
    check("ch1", 32'h0, {29'h0, oscRunCh1});
    wr(IDX_TRG, 16'h0000);
  endtask

  // Sensor B start is refused in the AC resistive and DC capacitive modes.
  task automatic sensorBModes();
    // A leftover time base of 1 would end sensor B before it is read.
    wr(IDX_TCL, 16'h0000);
    wr(IDX_TCH, 16'h0000);
    for (int m = 0; m < 3; m++) begin
      wr(IDX_CTL, {10'h000, m[1:0], 4'h1});
      wr(IDX_TRG, 16'h0004);
      check("mode", {30'h0, m[1:0]}, {30'h0, oscillationMode});
      rdChk("trgB", IDX_TRG, (m == 0) ? 32'h4 : 32'h0);
      wr(IDX_TRG, 16'h0000);
    end
  endtask

  // One run to its end, then flag, mask and clear behaviour.
  task automatic runOsc(input logic [15:0] ctl, trg,
                        input logic [23:0] mc, tc, input logic [4:0] fl);
    logic [31:0] x;
    int          n;
    wr(IDX_CTL, ctl);
    wr(IDX_IMSK, 16'h0000);
    wr(IDX_MCL, mc[15:0]);
    wr(IDX_MCH, {8'h00, mc[23:16]});
    wr(IDX_TCL, tc[15:0]);
    wr(IDX_TCH, {8'h00, tc[23:16]});
    wr(IDX_IFLG, 16'h001f);
    wr(IDX_TRG, trg);
    n = 0;
    do begin
      bus(1'b0, IDX_TRG, 16'h0000, x);
      n++;
    end while (x[2:0] !== 3'b000 && n < 2000);
    check("trgEnd", 32'h0, x);
    rdChk("flags", IDX_IFLG, {27'h0, fl});
    check("irqOff", 32'h0, {31'h0, irq});
    wr(IDX_IMSK, {11'h000, fl});
    check("irqOn", 32'h1, {31'h0, irq});
  endtask

  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    regsAfterReset();
    channelSteer();
    sensorBModes();
    // Each stop condition at least once, so every flag bit is reached.
    runOsc(16'h0001, 16'h0001, 24'hfffff0, 24'h000000, 5'h01);
    runOsc(16'h0001, 16'h0002, 24'h000000, 24'h000003, 5'h02);
    runOsc(16'h0003, 16'h0004, 24'h000000, 24'h000002, 5'h04);
    runOsc(16'h0001, 16'h0001, 24'h000000, 24'hfffffe, 5'h10);
    runOsc(16'h0001, 16'h0002, 24'hfffff8, 24'h000000, 5'h08);
    endOfTest();
  end

  // Cuts a hang short well after the expected run time.
  initial begin
    #400000;
    failCount++;
    endOfTest();
  end
endmodule
`default_nettype wire
